/* File: src/fbm_consts.svh */
// Timing counts and pin-level constants for the flash bus host controller
`ifndef FBM_CONSTS_SVH
`define FBM_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define FBM_CLK_PERIOD_NS   25
`define FBM_T_ACC_NS        70
`define FBM_T_OE_NS         30
`define FBM_T_WP_NS         35
`define FBM_T_RP_NS         500
`define FBM_SLEEP_EXTRA_NS  30
// Least times round up to whole cycles
`define FBM_CYC(ns) (((ns) + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Autoselect address fields
// ----------------------------------------------------------------------
`define FBM_ADDR_MFR        21'h00_0000
`define FBM_ADDR_DEVID      21'h00_0001
`define FBM_ADDR_PROT       21'h00_0002
`define FBM_HV_BIT          9
`define FBM_VARIANT_BIT     8
`define FBM_SECT_LSB        12
`define FBM_PROT_SET        8'h01
`define FBM_LOCK_BIT        0
`define FBM_TMO_BIT         5

`endif

/* File: src/fbm_pkg.sv */
// Types shared by the flash bus host controller
package fbm_pkg;

  // ----------------------------------------------------------------------
  // User commands
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FBM_OP_READ   = 3'b000,
    FBM_OP_WRITE  = 3'b001,
    FBM_OP_RESET  = 3'b010,
    FBM_OP_HV_ID  = 3'b011,
    FBM_OP_PROT   = 3'b100,
    FBM_OP_LOCK   = 3'b101
  } fbm_op_t;

  // ----------------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FBM_ST_IDLE  = 3'b000,
    FBM_ST_RD    = 3'b001,
    FBM_ST_WR    = 3'b010,
    FBM_ST_WREC  = 3'b011,
    FBM_ST_RST   = 3'b100,
    FBM_ST_DONE  = 3'b101
  } fbm_state_t;

endpackage

/* File: src/fbm_host.sv */
// Host controller driving a parallel NOR flash through its pins
`timescale 1ns/100ps
`include "fbm_consts.svh"

// Notes on behaviour
// - Host reports timeout bit on rsp_timeout; reset pulse only on the user reset command.
// - High-voltage autoselect: host raises select pin, reads ID codes.
// - Protect verify: sector address on top bits, 01h protected, 00h not.
// - Command autoselect keeps select pin at logic level.
// - Host holds variant pin high for maker ID.
// - Host writes with write enable and chip select low, output enable high.
module fbm_host
  import fbm_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // User command port
  input  wire logic              req_valid,
  input  wire logic [2:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              word_mode,
  input  wire logic              wp_assert,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_timeout,
  // Flash pins
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  output logic                   flash_byte_n,
  output logic                   flash_wp_n,
  output logic                   hv_select_addr_pin,
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic [DATA_W-1:0]      data_lines_oe
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [5:0] RD_CYC  = 6'(`FBM_CYC(`FBM_T_ACC_NS) + 1);
  localparam logic [5:0] WR_CYC  = 6'(`FBM_CYC(`FBM_T_WP_NS));
  localparam logic [5:0] RST_CYC = 6'(`FBM_CYC(`FBM_T_RP_NS));
  localparam logic [5:0] REC_CYC = 6'd1;

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] din_meta_q;
  logic [DATA_W-1:0] din_sync_q;

  // Data lines come from outside, so two stages before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      din_meta_q <= data_lines_i;
      din_sync_q <= din_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  fbm_state_t        state_q, state_d;
  logic [5:0]        cnt_q, cnt_d;
  fbm_op_t           op_q, op_d;
  logic              ce_n_q, ce_n_d;
  logic              oe_n_q, oe_n_d;
  logic              we_n_q, we_n_d;
  logic              rstp_n_q, rstp_n_d;
  logic              byte_n_q, byte_n_d;
  logic              wp_n_q, wp_n_d;
  logic              hv_q, hv_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic [DATA_W-1:0] doe_q, doe_d;
  logic              rdy_q, rdy_d;
  logic              rv_q, rv_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              tmo_q, tmo_d;

  // Mask read data to lines the device drives in the current width
  function automatic logic [DATA_W-1:0] fbm_mask(input logic [DATA_W-1:0] d,
                                                 input logic wide);
    fbm_mask = wide ? d : {{(DATA_W-8){1'b0}}, d[7:0]};
  endfunction

  // Next-state logic; one pin cycle at a time keeps timing easy to check
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    op_d     = op_q;
    ce_n_d   = ce_n_q;
    oe_n_d   = oe_n_q;
    we_n_d   = we_n_q;
    rstp_n_d = rstp_n_q;
    byte_n_d = byte_n_q;
    wp_n_d   = wp_assert ? 1'b0 : 1'b1;
    hv_d     = hv_q;
    addr_d   = addr_q;
    dout_d   = dout_q;
    doe_d    = doe_q;
    rdy_d    = rdy_q;
    rv_d     = 1'b0;
    rdata_d  = rdata_q;
    tmo_d    = tmo_q;
    case (state_q)
      FBM_ST_IDLE: begin
        // Idle: chip deselected so the device sits in standby
        ce_n_d = 1'b1;
        oe_n_d = 1'b1;
        we_n_d = 1'b1;
        doe_d  = '0;
        hv_d   = 1'b0;
        if (req_valid && rdy_q) begin
          op_d     = fbm_op_t'(req_op);
          rdy_d    = 1'b0;
          byte_n_d = word_mode;
          addr_d   = req_addr;
          cnt_d    = '0;
          case (fbm_op_t'(req_op))
            FBM_OP_READ: begin
              ce_n_d = 1'b0;
              oe_n_d = 1'b0;
              state_d = FBM_ST_RD;
            end
            FBM_OP_HV_ID, FBM_OP_PROT, FBM_OP_LOCK: begin
              // Elevated level on the select pin; low bits pick the code
              hv_d = 1'b1;
              ce_n_d = 1'b0;
              oe_n_d = 1'b0;
              if (fbm_op_t'(req_op) == FBM_OP_HV_ID) begin
                addr_d = `FBM_ADDR_MFR | (req_addr & `FBM_ADDR_DEVID);
                addr_d[`FBM_VARIANT_BIT] = 1'b1;
              end else begin
                // Sector address rides on the top bits
                addr_d = {req_addr[ADDR_W-1:`FBM_SECT_LSB],
                          {`FBM_SECT_LSB{1'b0}}} | `FBM_ADDR_PROT;
              end
              state_d = FBM_ST_RD;
            end
            FBM_OP_WRITE: begin
              ce_n_d = 1'b0;
              we_n_d = 1'b0;
              oe_n_d = 1'b1;
              dout_d = req_wdata;
              // Byte mode: upper lines left to the device, bit 15 is A-1
              doe_d  = word_mode ? '1 : {1'b1, 7'h00, 8'hFF};
              if (!word_mode) begin
                dout_d[DATA_W-1] = req_addr[0];
              end
              state_d = FBM_ST_WR;
            end
            FBM_OP_RESET: begin
              rstp_n_d = 1'b0;
              state_d  = FBM_ST_RST;
            end
            default: begin
              // Unknown command is answered with no bus cycle
              state_d = FBM_ST_DONE;
            end
          endcase
        end else begin
          rdy_d = 1'b1;
        end
      end
      FBM_ST_RD: begin
        // Address held stable for access time; sleep does not slow reads
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == RD_CYC) begin
          rdata_d = fbm_mask(din_sync_q, byte_n_q);
          if (op_q == FBM_OP_PROT) begin
            rdata_d = {8'h00, din_sync_q[7:0]};
          end else if (op_q == FBM_OP_LOCK) begin
            rdata_d = {15'h0000, din_sync_q[`FBM_LOCK_BIT]};
          end
          // Timeout flag tells software to send the reset command
          tmo_d  = din_sync_q[`FBM_TMO_BIT];
          oe_n_d = 1'b1;
          ce_n_d = 1'b1;
          state_d = FBM_ST_DONE;
        end
      end
      FBM_ST_WR: begin
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == WR_CYC) begin
          we_n_d  = 1'b1;
          cnt_d   = '0;
          state_d = FBM_ST_WREC;
        end
      end
      FBM_ST_WREC: begin
        // Hold data past the rising write edge, then release the lines
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == REC_CYC) begin
          ce_n_d  = 1'b1;
          doe_d   = '0;
          state_d = FBM_ST_DONE;
        end
      end
      FBM_ST_RST: begin
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == RST_CYC) begin
          rstp_n_d = 1'b1;
          tmo_d    = 1'b0;
          state_d  = FBM_ST_DONE;
        end
      end
      FBM_ST_DONE: begin
        hv_d    = 1'b0;
        rv_d    = 1'b1;
        state_d = FBM_ST_IDLE;
      end
      default: begin
        state_d = FBM_ST_IDLE;
      end
    endcase
  end

  // Register stage; all pins come straight from these flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= FBM_ST_IDLE;
      cnt_q    <= '0;
      op_q     <= FBM_OP_READ;
      ce_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      rstp_n_q <= 1'b1;
      byte_n_q <= 1'b1;
      wp_n_q   <= 1'b1;
      hv_q     <= 1'b0;
      addr_q   <= '0;
      dout_q   <= '0;
      doe_q    <= '0;
      rdy_q    <= 1'b0;
      rv_q     <= 1'b0;
      rdata_q  <= '0;
      tmo_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      op_q     <= op_d;
      ce_n_q   <= ce_n_d;
      oe_n_q   <= oe_n_d;
      we_n_q   <= we_n_d;
      rstp_n_q <= rstp_n_d;
      byte_n_q <= byte_n_d;
      wp_n_q   <= wp_n_d;
      hv_q     <= hv_d;
      addr_q   <= addr_d;
      dout_q   <= dout_d;
      doe_q    <= doe_d;
      rdy_q    <= rdy_d;
      rv_q     <= rv_d;
      rdata_q  <= rdata_d;
      tmo_q    <= tmo_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign req_ready          = rdy_q;
  assign rsp_valid          = rv_q;
  assign rsp_rdata          = rdata_q;
  assign rsp_timeout        = tmo_q;
  assign flash_ce_n         = ce_n_q;
  assign flash_oe_n         = oe_n_q;
  assign flash_we_n         = we_n_q;
  assign flash_reset_n      = rstp_n_q;
  assign flash_byte_n       = byte_n_q;
  assign flash_wp_n         = wp_n_q;
  assign hv_select_addr_pin = hv_q;
  assign flash_addr         = addr_q;
  assign data_lines_o       = dout_q;
  assign data_lines_oe      = doe_q;

endmodule

/* File: test/fbm_host_props.sv */
// Pin protocol checker for the flash host
`timescale 1ns/100ps
module fbm_host_props #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              req_valid,
  input wire logic [2:0]        req_op,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  input wire logic              flash_reset_n,
  input wire logic              flash_byte_n,
  input wire logic              hv_select_addr_pin,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] data_lines_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Read command taken at the user port
  sequence s_rd_take;
    req_valid && req_ready && req_op == 3'h0;
  endsequence
  // Reset pin low for the whole minimum pulse
  sequence s_rst_low;
    !flash_reset_n [*8] ##1 !flash_reset_n [*8] ##1 !flash_reset_n [*4];
  endsequence
  a_write_oe_high: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe with bad select or output enable");
  a_read_bus_free: assert property (!flash_oe_n |-> data_lines_oe == '0 && flash_we_n)
    else $error("host drives data during a read");
  a_hv_no_write: assert property (hv_select_addr_pin |-> flash_we_n)
    else $error("command write with elevated select pin");
  a_hv_bit6_low: assert property (hv_select_addr_pin && !flash_oe_n |-> !flash_addr[6])
    else $error("autoselect read with address bit 6 high");
  a_maker_variant: assert property (hv_select_addr_pin && !flash_oe_n
    && flash_addr[1:0] == 2'b00 |-> flash_addr[8])
    else $error("maker code read with variant bit low");
  a_read_answer: assert property (s_rd_take |-> ##7 rsp_valid)
    else $error("read answer not seven cycles after take");
  a_reset_pulse: assert property ($fell(flash_reset_n) |-> s_rst_low)
    else $error("reset pulse too short");
  a_ready_return: assert property (rsp_valid |=> req_ready && !rsp_valid)
    else $error("ready not back after answer");
  a_byte_hi_free: assert property (!flash_we_n && !flash_byte_n
    |-> data_lines_oe[14:8] == 7'h00 && data_lines_oe[15])
    else $error("byte mode write drives the wrong upper lines");
endmodule

bind fbm_host fbm_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_fbm_host_props (
  .core_clk, .rst_n, .req_valid, .req_op, .req_ready, .rsp_valid, .flash_ce_n, .flash_oe_n,
  .flash_we_n, .flash_reset_n, .flash_byte_n, .hv_select_addr_pin, .flash_addr,
  .data_lines_oe);

/* File: test/fbm_flash_model.sv */
// Behavioural model of the parallel flash device
`timescale 1ns/100ps
module fbm_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] CFG_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hA6, // Arbitrary value
  parameter logic [7:0] ID_HI    = 8'h11  // Arbitrary value
) (
  // Control and address pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        byte_n,
  input  wire logic        wp_n,
  input  wire logic        hv,
  input  wire logic [20:0] addr,
  // Data lines from both ends
  input  wire logic [15:0] host_o,
  input  wire logic [15:0] host_oe,
  output wire logic [15:0] bus
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] rd;
  logic [15:0] last;
  logic [15:0] en;
  logic        drv;

  // Read path; array reads need no command
  always @* begin
    drv = !ce_n && !oe_n && we_n && reset_n;
    en = {{8{drv && byte_n}}, {8{drv}}};
    // No suspend is ever entered here, so every read with hv low returns array data
    rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    if (hv) begin
      case (addr[1:0])
        2'b00: rd = {ID_HI, addr[8] ? MFR_CODE : CFG_CODE};
        2'b01: rd = {ID_HI, DEV_CODE};
        default: rd = {ID_HI, 7'h00, addr[20:12] == 9'h000};
      endcase
    end
    if (drv) last = rd;
  end

  // Released lines show the inverse of the last value, never a stale copy
  assign #60 bus = (host_oe & host_o) | (~host_oe & ((en & rd) | (~en & ~last)));

  // Program on rising strobe; boot sector ignored while protect pin low
  // The host never raises the accel level, so logic-level protect is all that applies
  always @(posedge we_n) begin
    if (!ce_n && reset_n && !hv && (wp_n || addr[20:12] != 9'h000)) begin
      mem[addr] = host_o;
    end
  end
endmodule

/* File: test/fbm_host_tb_top.sv */
// Self-checking bench for the flash bus host controller
`timescale 1ns/100ps
module fbm_host_tb_top;
  // Arbitrary identifier values for the device model
  localparam logic [7:0] MFR_CODE = 8'h5A;
  localparam logic [7:0] DEV_CODE = 8'hA6;
  localparam logic [7:0] ID_HI    = 8'h11;
  logic        core_clk, rst_n, req_valid, word_mode, wp_assert;
  logic        req_ready, rsp_valid, rsp_timeout, ce_n, oe_n, we_n, reset_n, byte_n, wp_n, hv;
  logic [2:0]  req_op;
  logic [20:0] req_addr, f_addr;
  logic [15:0] req_wdata, rsp_rdata, dl_i, dl_o, dl_oe;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  fbm_host i_fbm_host (
    .core_clk, .rst_n, .req_valid, .req_op, .req_addr, .req_wdata, .word_mode, .wp_assert,
    .req_ready, .rsp_valid, .rsp_rdata, .rsp_timeout, .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_n(reset_n), .flash_byte_n(byte_n), .flash_wp_n(wp_n),
    .hv_select_addr_pin(hv), .flash_addr(f_addr), .data_lines_i(dl_i), .data_lines_o(dl_o),
    .data_lines_oe(dl_oe));
  fbm_flash_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE), .ID_HI(ID_HI))
    i_fbm_flash_model (.ce_n, .oe_n, .we_n, .reset_n, .byte_n, .wp_n, .hv, .addr(f_addr),
    .host_o(dl_o), .host_oe(dl_oe), .bus(dl_i));

  // Clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command, held until taken, then wait for its answer
  task automatic xfer(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    check(16'(rsp_valid), 16'h0001);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_addr = 21'h00_0000;
    req_wdata = 16'h0000;
    word_mode = 1'b1;
    wp_assert = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(16'(ce_n), 16'h0001);
    xfer(3'h0, 21'h00_1234, 16'h0000);
    check(rsp_rdata, 16'hFFFF);
    check(16'(rsp_timeout), 16'h0001);
    xfer(3'h1, 21'h00_1234, 16'hA5C3);
    xfer(3'h0, 21'h00_1234, 16'h0000);
    check(rsp_rdata, 16'hA5C3);
    check(16'(ce_n), 16'h0001);
    word_mode <= 1'b0;
    xfer(3'h0, 21'h00_1234, 16'h0000);
    check(rsp_rdata, 16'h00C3);
    xfer(3'h1, 21'h00_2001, 16'h0077);
    xfer(3'h0, 21'h00_2001, 16'h0000);
    check(rsp_rdata, 16'h0077);
    $display("test array access done");
    for (int i = 0; i < 4; i++) begin
      word_mode <= i[1];
      xfer(3'h3, 21'(i[0]), 16'h0000);
      check(rsp_rdata, {i[1] ? ID_HI : 8'h00, i[0] ? DEV_CODE : MFR_CODE});
    end
    word_mode <= 1'b1;
    xfer(3'h4, 21'h00_0000, 16'h0000);
    check(rsp_rdata, 16'h0001);
    xfer(3'h4, 21'h00_1000, 16'h0000);
    check(rsp_rdata, 16'h0000);
    xfer(3'h5, 21'h00_0000, 16'h0000);
    check(rsp_rdata, 16'h0001);
    $display("test autoselect done");
    wp_assert <= 1'b1;
    xfer(3'h1, 21'h00_0005, 16'h1111);
    xfer(3'h0, 21'h00_0005, 16'h0000);
    check(rsp_rdata, 16'hFFFF);
    wp_assert <= 1'b0;
    xfer(3'h1, 21'h00_0005, 16'h1111);
    xfer(3'h0, 21'h00_0005, 16'h0000);
    check(rsp_rdata, 16'h1111);
    $display("test write protect done");
    xfer(3'h0, 21'h00_0040, 16'h0000);
    check(16'(rsp_timeout), 16'h0001);
    xfer(3'h2, 21'h00_0000, 16'h0000);
    check(16'(rsp_timeout), 16'h0000);
    xfer(3'h0, 21'h00_1234, 16'h0000);
    check(rsp_rdata, 16'hA5C3);
    $display("test hardware reset done");
    close_out();
  end
endmodule
